//--- bench/isb_i2c_master.sv
// Purpose: serial bus master model
// Assumes: lines pulled up, low while any party pulls
// Notes:   80 ns bit period at lag 0, waits while clock is held
`timescale 1ns/1ps
module isb_i2c_master
(
	input wire   scl,
	input wire   sda,
	output logic scl_dn,
	output logic sda_dn
);
	int lag = 0;
	initial
	begin
		scl_dn = 0;
		sda_dn = 0;
	end
	task automatic qt;
		#(20 + lag);
	endtask
	task automatic bt(input logic b, output logic r);
		sda_dn = !b;
		qt;
		scl_dn = 0;
		wait (scl === 1'b1);
		qt;
		r = sda;
		qt;
		scl_dn = 1;
		qt;
	endtask
	task automatic start;
		sda_dn = 0;
		qt;
		scl_dn = 0;
		wait (scl === 1'b1);
		qt;
		sda_dn = 1;
		qt;
		scl_dn = 1;
		qt;
	endtask
	task automatic stop;
		sda_dn = 1;
		qt;
		scl_dn = 0;
		wait (scl === 1'b1);
		qt;
		sda_dn = 0;
		qt;
	endtask
	task automatic wb(input logic [7:0] d, output logic a);
		logic x;
		for (int i = 7; i >= 0; i--)
			bt(d[i], x);
		bt(1, a);
	endtask
	task automatic rb(input logic nk, output logic [7:0] d);
		logic x;
		for (int i = 7; i >= 0; i--)
			bt(1, d[i]);
		bt(nk, x);
	endtask
endmodule // isb_i2c_master

//--- bench/isb_monitor.sv
// Purpose: port checker for isb_slave
// Assumes: sees the top module ports only
// Notes:   bound to every isb_slave
`timescale 1ns/1ps
`include "isb_map.vh"
module isb_monitor
(
	input wire        pclk,
	input wire        presetn,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        pslverr,
	input wire        scl_o,
	input wire        scl_oe,
	input wire        sda_o,
	input wire        int_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && pready;
	wire wr  = acc && pwrite;
	wire clr = wr && paddr == `ISB_A_CON && !pwdata[`ISB_CON_SI];
	sequence s_wait; psel && penable && !pready; endsequence
	sequence s_ans; pready ##1 !pready; endsequence
	property p_wait; s_wait |=> s_ans; endproperty
	property p_early; psel && !penable |=> !pready; endproperty
	property p_err; pslverr |-> pready; endproperty
	property p_unm; acc && paddr > `ISB_A_IMSK |-> pslverr; endproperty
	property p_od; scl_o == 1'b0 && sda_o == 1'b0; endproperty
	property p_hold; scl_oe == !int_n; endproperty
	property p_keep; !int_n && !wr && !$past(wr) |=> !int_n; endproperty
	property p_clr; clr && !int_n |-> ##2 int_n; endproperty
	a_wait: assert property (p_wait) else $error("wait state wrong");
	a_early: assert property (p_early) else $error("early ready");
	a_err: assert property (p_err) else $error("error without ready");
	a_unm: assert property (p_unm) else $error("unmapped not refused");
	a_od: assert property (p_od) else $error("line driven high");
	a_hold: assert property (p_hold) else $error("clock hold wrong");
	a_keep: assert property (p_keep) else $error("flag lost");
	a_clr: assert property (p_clr) else $error("flag not cleared");
endmodule // isb_monitor
bind isb_slave isb_monitor u_mon (.*);

//--- bench/isb_slave_tb.sv
// Purpose: self-checking bench of isb_slave
// Assumes: 250 MHz pclk, pulled-up serial lines
// Notes:   random data from a fixed seed
`timescale 1ns/1ps
`include "isb_map.vh"
module isb_slave_tb;
	logic        pclk = 0;
	logic        presetn = 0;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	wire  [31:0] prdata;
	wire         pready, pslverr, scl_oe, sda_oe, int_n, irq;
	wire         scl_dn, sda_dn;
	wire         scl = !(scl_oe | scl_dn);
	wire         sda = !(sda_oe | sda_dn);
	int          err_total = 0;
	int          checks_done = 0;
	int          n;
	logic [31:0] rs = 50554;
	logic [31:0] rd, t;
	logic        ak, er;
	logic [7:0]  q, ex[3];
	isb_slave dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
		.sda_i(sda), .sda_o(), .sda_oe(sda_oe), .int_n(int_n),
		.irq(irq));
	isb_i2c_master m (.scl(scl), .sda(sda), .scl_dn(scl_dn),
		.sda_dn(sda_dn));
	initial
		forever #2 pclk = ~pclk;
	function automatic logic [31:0] rnd;
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic chk(input string nm, input logic [7:0] e, s);
		checks_done++;
		if (s !== e)
		begin
			err_total++;
			$display("[FAIL] %s exp %h got %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic [7:0] a, d, input logic w);
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [7:0] a, d);
		apb(a, d, 1);
	endtask
	task automatic st(input logic [7:0] e);
		apb(`ISB_A_STA, 0, 0);
		chk("status", e, rd[7:0]);
	endtask
	task automatic con(input logic start_request, aa);
		wr(`ISB_A_CON, {1'b0, aa, start_request, 5'h01});
	endtask
	task automatic wint;
		int k;
		k = 0;
		while (int_n !== 1'b0 && k++ < 5000)
			@(posedge pclk);
		chk("int_n", 0, {7'h0, int_n});
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#300000;
		err_total++;
		final_report;
	end
	initial
	begin
		repeat (2) @(posedge pclk);
		presetn <= 1;
		st(`ISB_ST_IDLE);
		apb(8'h1c, 0, 0);
		chk("pslverr", 1, {7'h0, er});
		wr(`ISB_A_IMSK, 3);
		wr(`ISB_A_ADR, 8'h55);
		con(0, 1);
		m.start();
		m.wb(8'h55, ak);
		chk("ack", 0, {7'h0, ak});
		wint;
		chk("scl_oe", 1, {7'h0, scl_oe});
		chk("irq", 1, {7'h0, irq});
		st(`ISB_ST_SLAR);
		ex[0] = rnd();
		ex[1] = rnd();
		wr(`ISB_A_DAT, ex[0]);
		wr(`ISB_A_DAT, ex[1]);
		t = rnd();
		wr(`ISB_A_CNT, {t[7], 7'd2});
		con(0, 0);
		for (int i = 0; i < 2; i++)
		begin
			m.rb(0, q);
			chk("tx", ex[i], q);
		end
		wint;
		st(`ISB_ST_TC8);
		con(0, 0);
		m.rb(1, q);
		chk("tx", 8'hff, q);
		m.stop();
		m.start();
		m.wb(8'h55, ak);
		chk("ack", 1, {7'h0, ak});
		m.stop();
		con(0, 1);
		m.start();
		m.wb(8'h55, ak);
		chk("ack", 0, {7'h0, ak});
		wint;
		wr(`ISB_A_DAT, ex[1]);
		wr(`ISB_A_CNT, 1);
		con(0, 1);
		m.rb(1, q);
		chk("tx", ex[1], q);
		wint;
		st(`ISB_ST_TC0);
		con(1, 1);
		m.stop();
		wint;
		st(`ISB_ST_STRT);
		chk("sda_oe", 1, {7'h0, sda_oe});
		wr(`ISB_A_IMSK, 0);
		repeat (2) @(posedge pclk);
		chk("irq", 0, {7'h0, irq});
		wr(`ISB_A_IST, 3);
		wr(`ISB_A_IMSK, 3);
		repeat (2) @(posedge pclk);
		chk("irq", 0, {7'h0, irq});
		con(0, 1);
		m.lag = rnd() % 8;
		m.start();
		m.wb(8'h54, ak);
		chk("ack", 0, {7'h0, ak});
		wint;
		st(`ISB_ST_SLAW);
		wr(`ISB_A_CNT, 3);
		con(0, 1);
		m.wb(rnd(), ak);
		m.stop();
		wint;
		st(`ISB_ST_STOP);
		con(0, 0);
		m.start();
		m.wb(8'h00, ak);
		chk("ack", 0, {7'h0, ak});
		wint;
		st(`ISB_ST_GCW);
		t = rnd();
		n = 1 + t[1:0] % 3;
		wr(`ISB_A_CNT, {1'b1, n[6:0]});
		con(0, 0);
		for (int i = 0; i < n; i++)
		begin
			ex[i] = rnd();
			m.wb(ex[i], ak);
			chk("ack", {7'h0, i == n - 1}, {7'h0, ak});
		end
		wint;
		st(`ISB_ST_GE8);
		for (int i = 0; i < n; i++)
		begin
			apb(`ISB_A_DAT, 0, 0);
			chk("rx", ex[i], rd[7:0]);
		end
		con(0, 1);
		m.stop();
		m.start();
		con(1, 1);
		m.start();
		m.wb(8'h55, ak);
		wint;
		st(`ISB_ST_ALR);
		ex[0] = rnd();
		wr(`ISB_A_DAT, ex[0]);
		wr(`ISB_A_CNT, 1);
		con(0, 1);
		m.rb(1, q);
		chk("tx", ex[0], q);
		wint;
		st(`ISB_ST_TC0);
		con(0, 1);
		m.stop();
		final_report;
	end
endmodule // isb_slave_tb

//--- hw/isb_map.vh
// Purpose: constants of the buffered slave state block
// Assumes: 32-bit APB, byte offsets
// Notes:   definitions only
`ifndef ISB_MAP_VH
`define ISB_MAP_VH
`define ISB_A_STA   8'h00
`define ISB_A_DAT   8'h04
`define ISB_A_CNT   8'h08
`define ISB_A_CON   8'h0c
`define ISB_A_ADR   8'h10
`define ISB_A_IST   8'h14
`define ISB_A_IMSK  8'h18
`define ISB_CON_MODE 0
`define ISB_CON_SI   3
`define ISB_CON_STO  4
`define ISB_CON_STA  5
`define ISB_CON_AA   6
`define ISB_CNT_LB   7
`define ISB_ADR_GC   0
`define ISB_ST_IDLE 8'hf8
`define ISB_ST_STRT 8'h08
`define ISB_ST_SLAW 8'h60
`define ISB_ST_GCW  8'hd0
`define ISB_ST_R80  8'h80
`define ISB_ST_R88  8'h88
`define ISB_ST_GE0  8'he0
`define ISB_ST_GE8  8'he8
`define ISB_ST_STOP 8'ha0
`define ISB_ST_SLAR 8'ha8
`define ISB_ST_ALR  8'hb0
`define ISB_ST_TB8  8'hb8
`define ISB_ST_TC0  8'hc0
`define ISB_ST_TC8  8'hc8
`define ISB_BUF_LAST 7'd67
`define ISB_CLK_NS   4
`define ISB_HOLD_NS  600
`define ISB_HOLD_CYC ((`ISB_HOLD_NS + `ISB_CLK_NS - 1) / `ISB_CLK_NS)
`endif

//--- hw/isb_slave.v
// Purpose: buffered slave states of a parallel-to-serial bus controller
// Assumes: pclk 250 MHz; scl/sda open drain, oe high pulls low
// Notes:   registers over APB, one wait state per access
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "isb_map.vh"
module isb_slave
(
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        scl_i,
	output reg         scl_o,
	output reg         scl_oe,
	input  wire        sda_i,
	output reg         sda_o,
	output reg         sda_oe,
	output reg         int_n,
	output reg         irq
);
localparam S_IDLE = 4'd0;
localparam S_ADDR = 4'd1;
localparam S_AACK = 4'd2;
localparam S_WSI  = 4'd3;
localparam S_RX   = 4'd4;
localparam S_RACK = 4'd5;
localparam S_TX   = 4'd6;
localparam S_TACK = 4'd7;
localparam S_GEN  = 4'd8;
localparam [31:0] HOLD_W = `ISB_HOLD_CYC;
localparam [9:0]  HOLD   = HOLD_W[9:0];
reg  [7:0] mem [0:67];
reg  [7:0] status_code_reg;
reg  [6:0] byte_count_field;
reg        last_byte_nack;
reg        mode;
reg        ack_enable;
reg        si;
reg  [6:0] own_address_reg;
reg        general_call_enable;
reg  [1:0] int_sts;
reg  [1:0] int_msk;
reg  [6:0] wr_ptr;
reg  [6:0] rd_ptr;
reg  [3:0] state;
reg  [7:0] shreg;
reg  [3:0] bitcnt;
reg  [6:0] cnt;
reg        is_gc;
reg        is_read;
reg        term;
reg        arb_lost;
reg        start_pend;
reg        busy;
reg        nack;
reg  [9:0] hold;
reg        scl_s1;
reg        scl_s2;
reg        scl_p;
reg        sda_s1;
reg        sda_s2;
reg        sda_p;
wire       acc      = psel & penable;
wire       done     = acc & pready;
wire       wr       = done & pwrite;
wire       scl_rise = scl_s2 & ~scl_p;
wire       scl_fall = ~scl_s2 & scl_p;
wire       start_det = scl_s2 & scl_p & sda_p & ~sda_s2;
wire       stop_det  = scl_s2 & scl_p & ~sda_p & sda_s2;
wire [7:0] rx_byte  = {shreg[6:0], sda_s2};
wire       last     = (cnt + 7'd1) == byte_count_field;
wire       apb_dw   = wr & (paddr == `ISB_A_DAT);
wire       rx_st    = (state == S_RX) & scl_rise & (bitcnt == 4'd7);
wire [6:0] wr_nx    = (wr_ptr == `ISB_BUF_LAST) ? 7'd0 : wr_ptr + 7'd1;
wire [6:0] rd_nx    = (rd_ptr == `ISB_BUF_LAST) ? 7'd0 : rd_ptr + 7'd1;
////////////////////////////////////////////////////////////////////////////
// pin synchronisers
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		scl_s1 <= 1'b1;
		scl_s2 <= 1'b1;
		scl_p  <= 1'b1;
		sda_s1 <= 1'b1;
		sda_s2 <= 1'b1;
		sda_p  <= 1'b1;
	end
	else
	begin
		scl_s1 <= scl_i;
		scl_s2 <= scl_s1;
		scl_p  <= scl_s2;
		sda_s1 <= sda_i;
		sda_s2 <= sda_s1;
		sda_p  <= sda_s2;
	end
end
////////////////////////////////////////////////////////////////////////////
// data buffer
always @(posedge pclk)
begin
	if (apb_dw)
		mem[wr_ptr] <= pwdata[7:0];
	else if (rx_st)
		mem[wr_ptr] <= rx_byte;
end
////////////////////////////////////////////////////////////////////////////
// apb slave, registers and serial state machine
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		prdata <= 32'h0000_0000;
		pready <= 1'b0;
		pslverr <= 1'b0;
		scl_o <= 1'b0;
		sda_o <= 1'b0;
		scl_oe <= 1'b0;
		sda_oe <= 1'b0;
		int_n <= 1'b1;
		irq <= 1'b0;
		status_code_reg <= `ISB_ST_IDLE;
		byte_count_field <= 7'h00;
		last_byte_nack <= 1'b0;
		mode <= 1'b0;
		ack_enable <= 1'b0;
		si <= 1'b0;
		own_address_reg <= 7'h00;
		general_call_enable <= 1'b0;
		int_sts <= 2'h0;
		int_msk <= 2'h0;
		wr_ptr <= 7'h00;
		rd_ptr <= 7'h00;
		state <= S_IDLE;
		shreg <= 8'h00;
		bitcnt <= 4'h0;
		cnt <= 7'h00;
		is_gc <= 1'b0;
		is_read <= 1'b0;
		term <= 1'b0;
		arb_lost <= 1'b0;
		start_pend <= 1'b0;
		busy <= 1'b0;
		nack <= 1'b0;
		hold <= 10'h000;
	end
	else
	begin
		pready <= acc & ~pready;
		pslverr <= 1'b0;
		if (acc & ~pready)
		begin
			prdata <= 32'h0000_0000;
			case (paddr)
				`ISB_A_STA:  prdata[7:0] <= status_code_reg;
				`ISB_A_DAT:  prdata[7:0] <= mem[rd_ptr];
				`ISB_A_CNT:  prdata[7:0] <= {last_byte_nack, byte_count_field};
				`ISB_A_CON:  prdata[7:0] <= {1'b0, ack_enable, start_pend, 1'b0,
					si, 2'b00, mode};
				`ISB_A_ADR:  prdata[7:0] <= {own_address_reg, general_call_enable};
				`ISB_A_IST:  prdata[1:0] <= int_sts;
				`ISB_A_IMSK: prdata[1:0] <= int_msk;
				default:     pslverr <= 1'b1;
			endcase
		end
		if (done & ~pwrite & (paddr == `ISB_A_DAT))
			rd_ptr <= rd_nx;
		if (apb_dw | rx_st)
			wr_ptr <= wr_nx;
		if (wr)
		begin
			case (paddr)
				`ISB_A_CNT:
				begin
					last_byte_nack <= pwdata[`ISB_CNT_LB];
					byte_count_field <= pwdata[6:0];
				end
				`ISB_A_CON:
				begin
					mode <= pwdata[`ISB_CON_MODE];
					ack_enable <= pwdata[`ISB_CON_AA];
					si <= si & pwdata[`ISB_CON_SI];
					if (pwdata[`ISB_CON_STA])
						start_pend <= 1'b1;
					wr_ptr <= 7'h00;
					rd_ptr <= 7'h00;
				end
				`ISB_A_ADR:
				begin
					own_address_reg <= pwdata[7:1];
					general_call_enable <= pwdata[`ISB_ADR_GC];
				end
				`ISB_A_IMSK: int_msk <= pwdata[1:0];
				default: ;
			endcase
		end
		if (wr & (paddr == `ISB_A_IST))
			int_sts <= int_sts & ~pwdata[1:0];
		if (start_det)
			busy <= 1'b1;
		if (stop_det)
		begin
			busy <= 1'b0;
			int_sts[1] <= 1'b1;
		end
		case (state)
			S_IDLE:
			begin
				sda_oe <= 1'b0;
				if (start_det)
				begin
					if (start_pend)
					begin
						arb_lost <= 1'b1;
						start_pend <= 1'b0;
					end
					bitcnt <= 4'h0;
					state <= S_ADDR;
				end
				else if (start_pend & ~busy & scl_s2 & sda_s2)
				begin
					start_pend <= 1'b0;
					hold <= 10'h000;
					sda_oe <= 1'b1;
					state <= S_GEN;
				end
			end
			S_GEN:
			begin
				hold <= hold + 10'h001;
				if (hold == HOLD)
				begin
					si <= 1'b1;
					int_sts[0] <= 1'b1;
					status_code_reg <= `ISB_ST_STRT;
					term <= 1'b1;
					state <= S_WSI;
				end
			end
			S_ADDR:
			begin
				if (stop_det)
					state <= S_IDLE;
				else if (start_det)
				begin
					if (start_pend)
					begin
						arb_lost <= 1'b1;
						start_pend <= 1'b0;
					end
					bitcnt <= 4'h0;
				end
				else if (scl_rise)
				begin
					shreg <= rx_byte;
					bitcnt <= bitcnt + 4'h1;
					if (bitcnt == 4'd7)
					begin
						bitcnt <= 4'h0;
						is_read <= sda_s2;
						is_gc <= 1'b0;
						if (ack_enable & (shreg[6:0] == own_address_reg))
							state <= S_AACK;
						else if (general_call_enable & (rx_byte == 8'h00))
						begin
							is_gc <= 1'b1;
							state <= S_AACK;
						end
						else
							state <= S_IDLE;
					end
				end
			end
			S_AACK:
			begin
				if (scl_fall)
				begin
					bitcnt <= bitcnt + 4'h1;
					sda_oe <= (bitcnt == 4'h0);
					if (bitcnt == 4'h1)
					begin
						si <= 1'b1;
						int_sts[0] <= 1'b1;
						term <= 1'b0;
						cnt <= 7'h00;
						arb_lost <= 1'b0;
						state <= S_WSI;
						if (is_gc)
							status_code_reg <= `ISB_ST_GCW;
						else if (~is_read)
							status_code_reg <= `ISB_ST_SLAW;
						else if (arb_lost)
							status_code_reg <= `ISB_ST_ALR;
						else
							status_code_reg <= `ISB_ST_SLAR;
					end
				end
			end
			S_WSI:
			begin
				if (~si)
				begin
					bitcnt <= 4'h0;
					cnt <= 7'h00;
					if (term)
						state <= S_IDLE;
					else if (is_read)
					begin
						shreg <= mem[rd_ptr];
						rd_ptr <= rd_nx;
						sda_oe <= ~mem[rd_ptr][7];
						state <= S_TX;
					end
					else
						state <= S_RX;
				end
			end
			S_RX, S_RACK:
			begin
				if (start_det | stop_det)
				begin
					sda_oe <= 1'b0;
					si <= 1'b1;
					int_sts[0] <= 1'b1;
					status_code_reg <= `ISB_ST_STOP;
					term <= 1'b1;
					state <= S_WSI;
				end
				else if (state == S_RX)
				begin
					if (scl_rise)
					begin
						shreg <= rx_byte;
						bitcnt <= bitcnt + 4'h1;
						if (bitcnt == 4'd7)
						begin
							bitcnt <= 4'h0;
							nack <= last_byte_nack & last;
							state <= S_RACK;
						end
					end
				end
				else if (scl_fall)
				begin
					bitcnt <= bitcnt + 4'h1;
					sda_oe <= (bitcnt == 4'h0) & ~nack;
					if (bitcnt == 4'h1)
					begin
						bitcnt <= 4'h0;
						cnt <= cnt + 7'h01;
						state <= S_RX;
						if (last)
						begin
							si <= 1'b1;
							int_sts[0] <= 1'b1;
							term <= nack;
							state <= S_WSI;
							if (is_gc)
								status_code_reg <= nack ? `ISB_ST_GE8 :
									`ISB_ST_GE0;
							else
								status_code_reg <= nack ? `ISB_ST_R88 :
									`ISB_ST_R80;
						end
					end
				end
			end
			S_TX:
			begin
				if (stop_det)
					state <= S_IDLE;
				else if (scl_fall)
				begin
					bitcnt <= bitcnt + 4'h1;
					shreg <= {shreg[6:0], 1'b0};
					sda_oe <= (bitcnt != 4'd7) & ~shreg[6];
					if (bitcnt == 4'd7)
					begin
						bitcnt <= 4'h0;
						state <= S_TACK;
					end
				end
			end
			S_TACK:
			begin
				if (stop_det)
					state <= S_IDLE;
				else if (scl_rise)
					nack <= sda_s2;
				else if (scl_fall)
				begin
					cnt <= cnt + 7'h01;
					if (~nack & ~last)
					begin
						shreg <= mem[rd_ptr];
						rd_ptr <= rd_nx;
						sda_oe <= ~mem[rd_ptr][7];
						state <= S_TX;
					end
					else
					begin
						si <= 1'b1;
						int_sts[0] <= 1'b1;
						state <= S_WSI;
						term <= nack | ~ack_enable;
						if (nack)
							status_code_reg <= `ISB_ST_TC0;
						else if (ack_enable)
							status_code_reg <= `ISB_ST_TB8;
						else
							status_code_reg <= `ISB_ST_TC8;
					end
				end
			end
			default: state <= S_IDLE;
		endcase
		scl_oe <= si;
		int_n <= ~si;
		irq <= |(int_sts & int_msk);
	end
end
endmodule // isb_slave
